// file: src/tmc_pkg.sv
`default_nettype none
package tmc_pkg;
   // register byte offsets
   localparam logic [7:0] CFG_OFS = 8'h00;
   localparam logic [7:0] AMODE_OFS = 8'h04;
   localparam logic [7:0] BMODE_OFS = 8'h08;
   localparam logic [7:0] CTL_OFS = 8'h0c;
   // mode register fields
   localparam int MR_MODE_LSB = 0;
   localparam int MR_CMR_BIT = 2;
   localparam int MR_AMS_BIT = 3;
   localparam int MR_WIDTH = 4;
   localparam int CFG_WIDTH = 3;
   // control register fields
   localparam int CTL_AEN_BIT = 0;
   localparam int CTL_ASTALL_BIT = 1;
   localparam int CTL_AEV_LSB = 2;
   localparam int CTL_RTC_RUN_BIT = 4;
   localparam int CTL_AOTE_BIT = 5;
   localparam int CTL_APWMINV_BIT = 6;
   localparam int CTL_RSV7_BIT = 7;
   localparam int CTL_BEN_BIT = 8;
   localparam int CTL_BSTALL_BIT = 9;
   localparam int CTL_BEV_LSB = 10;
   localparam int CTL_RSV12_BIT = 12;
   localparam int CTL_WIDTH = 13;
   localparam logic [31:0] CTL_WMASK = 32'h0000_0f7f;
   // reset values
   localparam logic [2:0] CFG_RST = 3'h0;
   localparam logic [3:0] MR_RST = 4'h0;
   localparam logic [12:0] CTL_RST = 13'h0000;

   typedef enum logic [2:0] {
      TMC_CFG_32 = 3'b000,
      TMC_CFG_RTC = 3'b001,
      TMC_CFG_RSV2 = 3'b010,
      TMC_CFG_RSV3 = 3'b011,
      TMC_CFG_16 = 3'b100
   } tmc_width_e;

   typedef enum logic [1:0] {
      TMC_MODE_RSV = 2'b00,
      TMC_MODE_ONESHOT = 2'b01,
      TMC_MODE_PERIODIC = 2'b10,
      TMC_MODE_CAPTURE = 2'b11
   } tmc_mode_e;

   typedef enum logic [1:0] {
      TMC_EDGE_RISE = 2'b00,
      TMC_EDGE_FALL = 2'b01,
      TMC_EDGE_RSV = 2'b10,
      TMC_EDGE_BOTH = 2'b11
   } tmc_edge_e;

   // decoded per-half operating setup
   typedef struct packed {
      logic run;
      logic one_shot;
      logic periodic;
      logic capture;
      logic edge_time;
      logic pwm;
      logic rise_edge;
      logic fall_edge;
   } tmc_half_s;

   // plain register bus request
   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } tmc_bus_s;
endpackage : tmc_pkg
`default_nettype wire

// file: src/tmc_half_dec.sv
`default_nettype none
module tmc_half_dec
   import tmc_pkg::*;
(
   // configuration
   input wire logic [3:0] mode_i,
   input wire logic [1:0] edge_i,
   input wire logic en_i,
   input wire logic stall_i,
   input wire logic dbg_halt_i,
   input wire logic valid_i,
   // decoded setup
   output tmc_half_s half_o
);
   wire logic [1:0] mfield = mode_i[MR_MODE_LSB +: 2];
   wire logic frozen = stall_i & dbg_halt_i;
   wire logic capture = (mfield == TMC_MODE_CAPTURE);

   assign half_o.run = en_i & valid_i & ~frozen;
   assign half_o.one_shot = (mfield == TMC_MODE_ONESHOT);
   assign half_o.periodic = (mfield == TMC_MODE_PERIODIC);
   // alternate select blocks capture; pwm needs periodic mode with bit two clear
   assign half_o.capture = capture & ~mode_i[MR_AMS_BIT];
   assign half_o.edge_time = mode_i[MR_CMR_BIT];
   assign half_o.pwm = mode_i[MR_AMS_BIT] & ~mode_i[MR_CMR_BIT]
                       & (mfield == TMC_MODE_PERIODIC);
   assign half_o.rise_edge = (edge_i == TMC_EDGE_RISE) ||
                             (edge_i == TMC_EDGE_BOTH);
   assign half_o.fall_edge = (edge_i == TMC_EDGE_FALL) ||
                             (edge_i == TMC_EDGE_BOTH);
endmodule : tmc_half_dec
`default_nettype wire

// file: src/tmc_out_gate.sv
`default_nettype none
module tmc_out_gate
   import tmc_pkg::*;
(
   input wire logic pwm_raw_i,
   input wire logic trig_raw_i,
   input wire logic pwm_inv_i,
   input wire logic trig_en_i,
   output logic pwm_o,
   output logic trig_o
);
   assign pwm_o = pwm_raw_i ^ pwm_inv_i;
   assign trig_o = trig_raw_i & trig_en_i;
endmodule : tmc_out_gate
`default_nettype wire

// file: src/tmc_regs.sv
// Overview of operation
// - second capture style bit two: count/time
// - mode 1 one-shot, 2 periodic, 3 capture
// - mode meaning follows global width config
// - split config: second mode field governs half
// - 32-bit config: use first mode register
// - edge field: rise, fall, both; 2 reserved
// - stall bit freezes second timer in halt
// - stall bit ignored while processor runs
// - bit eight enables second timer
// - bit six inverts first pwm output
// - bit five enables first adc trigger
// - control bits 12 and 7 read zero
// - config 0 32-bit, 1 rtc, 4-7 split
`default_nettype none
module tmc_regs
   import tmc_pkg::*;
(
   // clock, reset, enable
   input wire logic SYS_CLK_I,
   input wire logic RSTN_I,
   input wire logic CE_I,
   // register port
   input wire logic [7:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   // debugger and first-half raw outputs
   input wire logic DBG_HALT_I,
   input wire logic A_PWM_RAW_I,
   input wire logic A_TRIG_RAW_I,
   // decoded configuration
   output logic [2:0] WIDTH_CFG_O,
   output tmc_half_s A_HALF_O,
   output tmc_half_s B_HALF_O,
   output logic A_PWM_O,
   output logic A_TRIG_O
);
   tmc_bus_s bus;
   logic [2:0] global_width_config_r;
   logic [2:0] global_width_config_nxt;
   logic [3:0] first_timer_mode_reg_r;
   logic [3:0] first_timer_mode_reg_nxt;
   logic [3:0] second_timer_mode_reg_r;
   logic [3:0] second_timer_mode_reg_nxt;
   logic [12:0] timer_control_reg_r;
   logic [12:0] timer_control_reg_nxt;
   logic [31:0] rdata_r;
   logic [31:0] rdata_nxt;

   assign bus = '{addr: ADDR_I, wdata: WDATA_I, wr: WR_I, rd: RD_I};

   // address decode
   wire logic hit_cfg = (bus.addr == CFG_OFS);
   wire logic hit_am = (bus.addr == AMODE_OFS);
   wire logic hit_bm = (bus.addr == BMODE_OFS);
   wire logic hit_ctl = (bus.addr == CTL_OFS);
   wire logic wr_cfg = bus.wr & hit_cfg;
   wire logic wr_am = bus.wr & hit_am;
   wire logic wr_bm = bus.wr & hit_bm;
   wire logic wr_ctl = bus.wr & hit_ctl;
   wire logic [31:0] ctl_wval = bus.wdata & CTL_WMASK;

   assign global_width_config_nxt = wr_cfg ?
      bus.wdata[CFG_WIDTH-1:0] : global_width_config_r;
   assign first_timer_mode_reg_nxt = wr_am ?
      bus.wdata[MR_WIDTH-1:0] : first_timer_mode_reg_r;
   assign second_timer_mode_reg_nxt = wr_bm ?
      bus.wdata[MR_WIDTH-1:0] : second_timer_mode_reg_r;
   assign timer_control_reg_nxt = wr_ctl ?
      ctl_wval[CTL_WIDTH-1:0] : timer_control_reg_r;

   // unmapped addresses read as zero
   wire logic [31:0] rd_mux =
      hit_cfg ? {29'h0, global_width_config_r} :
      hit_am ? {28'h0, first_timer_mode_reg_r} :
      hit_bm ? {28'h0, second_timer_mode_reg_r} :
      hit_ctl ? {19'h0, timer_control_reg_r} : 32'h0;
   assign rdata_nxt = bus.rd ? rd_mux : 32'h0;

   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I) begin
         global_width_config_r <= CFG_RST;
         first_timer_mode_reg_r <= MR_RST;
         second_timer_mode_reg_r <= MR_RST;
         timer_control_reg_r <= CTL_RST;
         rdata_r <= 32'h0;
      end else if (CE_I) begin
         global_width_config_r <= global_width_config_nxt;
         first_timer_mode_reg_r <= first_timer_mode_reg_nxt;
         second_timer_mode_reg_r <= second_timer_mode_reg_nxt;
         timer_control_reg_r <= timer_control_reg_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign RDATA_O = rdata_r;
   assign WIDTH_CFG_O = global_width_config_r;

   // width decode: bit 2 marks split halves
   wire logic split16 = global_width_config_r[2];
   wire logic cfg32 = (global_width_config_r == TMC_CFG_32);
   wire logic cfg_rtc = (global_width_config_r == TMC_CFG_RTC);
   wire logic cfg_ok = split16 | cfg32 | cfg_rtc;

   // in 32-bit mode the second mode register is not looked at
   wire logic [3:0] b_mode_eff =
      split16 ? second_timer_mode_reg_r
              : first_timer_mode_reg_r;

   wire logic [1:0] a_edge =
      timer_control_reg_r[CTL_AEV_LSB +: 2];
   wire logic [1:0] b_edge =
      timer_control_reg_r[CTL_BEV_LSB +: 2];

   tmc_half_dec u_dec_a (
      .mode_i(first_timer_mode_reg_r),
      .edge_i(a_edge),
      .en_i(timer_control_reg_r[CTL_AEN_BIT]),
      .stall_i(timer_control_reg_r[CTL_ASTALL_BIT]),
      .dbg_halt_i(DBG_HALT_I),
      .valid_i(cfg_ok),
      .half_o(A_HALF_O)
   );

   // second half runs only as its own 16-bit timer
   tmc_half_dec u_dec_b (
      .mode_i(b_mode_eff),
      .edge_i(b_edge),
      .en_i(timer_control_reg_r[CTL_BEN_BIT]),
      .stall_i(timer_control_reg_r[CTL_BSTALL_BIT]),
      .dbg_halt_i(DBG_HALT_I),
      .valid_i(split16),
      .half_o(B_HALF_O)
   );

   tmc_out_gate u_gate (
      .pwm_raw_i(A_PWM_RAW_I),
      .trig_raw_i(A_TRIG_RAW_I),
      .pwm_inv_i(timer_control_reg_r[CTL_APWMINV_BIT]),
      .trig_en_i(timer_control_reg_r[CTL_AOTE_BIT]),
      .pwm_o(A_PWM_O),
      .trig_o(A_TRIG_O)
   );

   // helper: control was read one cycle back
   logic ctl_rd_prev_r;
   always_ff @(posedge SYS_CLK_I) begin
      if (!RSTN_I)
         ctl_rd_prev_r <= 1'b0;
      else if (CE_I)
         ctl_rd_prev_r <= bus.rd & hit_ctl;
   end

   chk_rsv_bits_zero: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      ctl_rd_prev_r |-> (RDATA_O[CTL_RSV7_BIT] == 1'b0 &&
                         RDATA_O[CTL_RSV12_BIT] == 1'b0))
      else $error("reserved control bits read nonzero");

   chk_write_lands: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (CE_I && wr_bm) |=> (second_timer_mode_reg_r ==
                          $past(bus.wdata[MR_WIDTH-1:0])))
      else $error("mode write did not land next edge");

   chk_b_ignored_32: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      cfg32 |-> (B_HALF_O.edge_time == first_timer_mode_reg_r[MR_CMR_BIT]))
      else $error("second mode used in 32-bit config");

   chk_b_split_mode: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      split16 |-> (B_HALF_O.periodic ==
         (second_timer_mode_reg_r[1:0] == TMC_MODE_PERIODIC)))
      else $error("second mode field not followed when split");

   chk_capture_style: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      split16 |-> (B_HALF_O.edge_time == second_timer_mode_reg_r[2]))
      else $error("capture style mismatch");

   chk_mode_onehot: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (split16 && second_timer_mode_reg_r[1:0] == TMC_MODE_ONESHOT)
      |-> (B_HALF_O.one_shot && !B_HALF_O.periodic))
      else $error("one-shot decode wrong");

   chk_edge_both: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (b_edge == TMC_EDGE_BOTH) |->
         (B_HALF_O.rise_edge && B_HALF_O.fall_edge))
      else $error("both-edge decode wrong");

   chk_edge_fall_only: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (b_edge == TMC_EDGE_FALL) |->
         (!B_HALF_O.rise_edge && B_HALF_O.fall_edge))
      else $error("falling-edge decode wrong");

   chk_stall_freeze: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (DBG_HALT_I && timer_control_reg_r[CTL_BSTALL_BIT]) |->
         !B_HALF_O.run)
      else $error("second timer runs while stalled in halt");

   chk_stall_ignored: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (!DBG_HALT_I && split16 && timer_control_reg_r[CTL_BEN_BIT]) |->
         B_HALF_O.run)
      else $error("stall acted without debug halt");

   chk_enable_off: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      !timer_control_reg_r[CTL_BEN_BIT] |-> !B_HALF_O.run)
      else $error("second timer runs while disabled");

   chk_pwm_invert: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      A_PWM_O == (A_PWM_RAW_I ^ timer_control_reg_r[CTL_APWMINV_BIT]))
      else $error("pwm inversion wrong");

   chk_trig_gate: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      !timer_control_reg_r[CTL_AOTE_BIT] |-> !A_TRIG_O)
      else $error("adc trigger leaked while disabled");

   chk_cfg_split: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      !split16 |-> !B_HALF_O.run)
      else $error("second half ran outside split config");

   chk_mode_reserved: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (split16 && second_timer_mode_reg_r[1:0] == TMC_MODE_RSV) |->
         !(B_HALF_O.one_shot || B_HALF_O.periodic || B_HALF_O.capture))
      else $error("reserved mode selected a function");

   chk_mode_periodic: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (split16 && second_timer_mode_reg_r[1:0] == TMC_MODE_PERIODIC) |->
         (B_HALF_O.periodic && !B_HALF_O.one_shot && !B_HALF_O.capture))
      else $error("periodic decode wrong");

   chk_mode_capture: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (split16 && second_timer_mode_reg_r[1:0] == TMC_MODE_CAPTURE &&
       !second_timer_mode_reg_r[MR_AMS_BIT]) |->
         (B_HALF_O.capture && !B_HALF_O.periodic && !B_HALF_O.pwm))
      else $error("capture decode wrong");

   chk_count_style: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (split16 && !second_timer_mode_reg_r[MR_CMR_BIT]) |->
         !B_HALF_O.edge_time)
      else $error("edge-count style not selected");

   chk_pwm_select: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (split16 && second_timer_mode_reg_r == 4'ha) |->
         (B_HALF_O.pwm && B_HALF_O.periodic && !B_HALF_O.capture))
      else $error("pwm setup not decoded");

   chk_alt_no_capture: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (split16 && second_timer_mode_reg_r[MR_AMS_BIT]) |->
         !B_HALF_O.capture)
      else $error("capture flagged with alternate select");

   chk_b_follow_first: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      cfg32 |-> (B_HALF_O.periodic ==
         (first_timer_mode_reg_r[1:0] == TMC_MODE_PERIODIC)))
      else $error("second decode not from first mode register");

   chk_b_write_ignored: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (cfg32 && CE_I && wr_bm) |=> $stable(B_HALF_O))
      else $error("second mode write acted in 32-bit config");

   chk_enable_on: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (split16 && timer_control_reg_r[CTL_BEN_BIT] &&
       !timer_control_reg_r[CTL_BSTALL_BIT]) |-> B_HALF_O.run)
      else $error("second timer idle while enabled");

   chk_edge_rise_only: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (b_edge == TMC_EDGE_RISE) |->
         (B_HALF_O.rise_edge && !B_HALF_O.fall_edge))
      else $error("rising-edge decode wrong");

   chk_edge_reserved: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (b_edge == TMC_EDGE_RSV) |->
         (!B_HALF_O.rise_edge && !B_HALF_O.fall_edge))
      else $error("reserved edge code selected an edge");

   chk_pwm_plain: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      !timer_control_reg_r[CTL_APWMINV_BIT] |-> (A_PWM_O == A_PWM_RAW_I))
      else $error("pwm output changed while not inverted");

   chk_trig_pass: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (timer_control_reg_r[CTL_AOTE_BIT] && A_TRIG_RAW_I) |-> A_TRIG_O)
      else $error("adc trigger lost while enabled");

   chk_rsv_write_ignored: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (CE_I && wr_ctl) |=> (timer_control_reg_r[CTL_RSV7_BIT] == 1'b0 &&
                            timer_control_reg_r[CTL_RSV12_BIT] == 1'b0))
      else $error("reserved control bit took a write");

   chk_rdata_upper: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      ctl_rd_prev_r |-> (RDATA_O[31:CTL_WIDTH] == '0))
      else $error("control read shows bits above the field");

   chk_ctl_write_lands: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (CE_I && wr_ctl) |=> (timer_control_reg_r ==
                           $past(ctl_wval[CTL_WIDTH-1:0])))
      else $error("control write did not land next edge");

   chk_cfg_write_lands: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (CE_I && wr_cfg) |=> (global_width_config_r ==
                           $past(bus.wdata[CFG_WIDTH-1:0])))
      else $error("config write did not land next edge");

   chk_reset_clears: assert property (
      @(posedge SYS_CLK_I)
      !RSTN_I |=> (timer_control_reg_r == CTL_RST &&
                   second_timer_mode_reg_r == MR_RST &&
                   global_width_config_r == CFG_RST && RDATA_O == 32'h0))
      else $error("reset left a register set");

   chk_ce_freeze: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      !CE_I |=> ($stable(timer_control_reg_r) && $stable(RDATA_O) &&
                 $stable(second_timer_mode_reg_r)))
      else $error("state moved while clock enable low");

   chk_rdata_idle: assert property (
      @(posedge SYS_CLK_I) disable iff (!RSTN_I)
      (CE_I && !bus.rd) |=> (RDATA_O == 32'h0))
      else $error("read data stood past its cycle");

   cov_split_periodic: cover property (@(posedge SYS_CLK_I)
      split16 && B_HALF_O.periodic && B_HALF_O.run);
   cov_pwm_setup: cover property (@(posedge SYS_CLK_I)
      split16 && B_HALF_O.pwm);
   cov_stalled: cover property (@(posedge SYS_CLK_I)
      DBG_HALT_I && timer_control_reg_r[CTL_BSTALL_BIT]);
   cov_trig_out: cover property (@(posedge SYS_CLK_I) A_TRIG_O);
endmodule : tmc_regs
`default_nettype wire

// file: bench/tb_tmc_regs.sv
`default_nettype none
module tb_tmc_regs
   import tmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   typedef struct packed {
      logic [2:0] cfg;
      logic [3:0] am;
      logic [3:0] bm;
      logic [31:0] ctl;
      logic halt;
      logic praw;
      logic traw;
      logic [7:0] bexp;
      logic pexp;
      logic texp;
   } tmc_row_s;

   logic SYS_CLK_I, RSTN_I, CE_I, WR_I, RD_I;
   logic [7:0] ADDR_I;
   logic [31:0] WDATA_I, RDATA_O, rdat, bgot, bwant;
   logic DBG_HALT_I, A_PWM_RAW_I, A_TRIG_RAW_I, A_PWM_O, A_TRIG_O;
   logic [2:0] WIDTH_CFG_O;
   tmc_half_s A_HALF_O, B_HALF_O;
   int mismatches = 0;
   int checks_done = 0;
   tmc_row_s rows [11];
   logic [7:0] ofs [4] = '{CFG_OFS, AMODE_OFS, BMODE_OFS, CTL_OFS};
   // reserved upper bits must read back as zero
   logic [31:0] rmask [4] = '{32'h7, 32'hf, 32'hf, 32'hf7f};

   tmc_regs i_dut (
      .SYS_CLK_I(SYS_CLK_I), .RSTN_I(RSTN_I), .CE_I(CE_I),
      .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I),
      .RDATA_O(RDATA_O), .DBG_HALT_I(DBG_HALT_I),
      .A_PWM_RAW_I(A_PWM_RAW_I), .A_TRIG_RAW_I(A_TRIG_RAW_I),
      .WIDTH_CFG_O(WIDTH_CFG_O), .A_HALF_O(A_HALF_O),
      .B_HALF_O(B_HALF_O), .A_PWM_O(A_PWM_O), .A_TRIG_O(A_TRIG_O)
   );

   initial begin
      SYS_CLK_I = 1'b0;
      forever #50 SYS_CLK_I = ~SYS_CLK_I;
   end

   task automatic complete_run;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : complete_run

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge SYS_CLK_I);
      ADDR_I <= a;
      WDATA_I <= d;
      WR_I <= 1'b1;
      RD_I <= 1'b0;
   endtask : wr

   // read data stands only in the cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge SYS_CLK_I);
      ADDR_I <= a;
      WR_I <= 1'b0;
      RD_I <= 1'b1;
      @(posedge SYS_CLK_I);
      RD_I <= 1'b0;
      #1;
      d = RDATA_O;
   endtask : rd

   initial begin
      // generous: the whole sequence needs about 125 cycles
      repeat (5000) @(posedge SYS_CLK_I);
      mismatches++;
      complete_run();
   end

   initial begin
      rows = '{
         '{3'h4, 4'h0, 4'h1, 32'h160, 1'b0, 1'b1, 1'b1, 8'hc2, 1'b0, 1'b1},
         '{3'h4, 4'h0, 4'h2, 32'h500, 1'b0, 1'b1, 1'b1, 8'ha1, 1'b1, 1'b0},
         '{3'h4, 4'h0, 4'h7, 32'hd40, 1'b0, 1'b0, 1'b0, 8'h9b, 1'b1, 1'b0},
         '{3'h4, 4'h0, 4'ha, 32'h920, 1'b0, 1'b0, 1'b1, 8'ha4, 1'b0, 1'b1},
         '{3'h5, 4'h0, 4'h1, 32'h300, 1'b1, 1'b0, 1'b0, 8'h42, 1'b0, 1'b0},
         '{3'h6, 4'h0, 4'h1, 32'h300, 1'b0, 1'b0, 1'b0, 8'hc2, 1'b0, 1'b0},
         '{3'h7, 4'h0, 4'h1, 32'h100, 1'b1, 1'b0, 1'b0, 8'hc2, 1'b0, 1'b0},
         '{3'h4, 4'h0, 4'h1, 32'h000, 1'b0, 1'b0, 1'b0, 8'h42, 1'b0, 1'b0},
         '{3'h0, 4'h2, 4'h1, 32'h100, 1'b0, 1'b0, 1'b0, 8'h22, 1'b0, 1'b0},
         '{3'h1, 4'h1, 4'h2, 32'h100, 1'b0, 1'b0, 1'b0, 8'h42, 1'b0, 1'b0},
         '{3'h4, 4'h0, 4'hb, 32'h100, 1'b0, 1'b0, 1'b0, 8'h82, 1'b0, 1'b0}};
      RSTN_I = 1'b0;
      CE_I = 1'b1;
      ADDR_I = 8'h00;
      WDATA_I = 32'h0;
      WR_I = 1'b0;
      RD_I = 1'b0;
      DBG_HALT_I = 1'b0;
      A_PWM_RAW_I = 1'b0;
      A_TRIG_RAW_I = 1'b0;
      repeat (10) @(posedge SYS_CLK_I);
      RSTN_I <= 1'b1;
      foreach (rows[i]) begin
         wr(CFG_OFS, {29'h0, rows[i].cfg});
         wr(AMODE_OFS, {28'h0, rows[i].am});
         wr(BMODE_OFS, {28'h0, rows[i].bm});
         wr(CTL_OFS, rows[i].ctl);
         @(posedge SYS_CLK_I);
         WR_I <= 1'b0;
         DBG_HALT_I <= rows[i].halt;
         A_PWM_RAW_I <= rows[i].praw;
         A_TRIG_RAW_I <= rows[i].traw;
         #1;
         bgot = {24'h0, B_HALF_O};
         bwant = {24'h0, rows[i].bexp};
         chk(bgot & 32'h80, bwant & 32'h80);
         chk(bgot & 32'h70, bwant & 32'h70);
         chk(bgot & 32'h08, bwant & 32'h08);
         chk(bgot & 32'h04, bwant & 32'h04);
         chk(bgot & 32'h03, bwant & 32'h03);
         chk({31'h0, A_PWM_O}, {31'h0, rows[i].pexp});
         chk({31'h0, A_TRIG_O}, {31'h0, rows[i].texp});
         chk({29'h0, WIDTH_CFG_O}, {29'h0, rows[i].cfg});
         rd(CTL_OFS, rdat);
         chk(rdat, rows[i].ctl);
         $display("test row %0d done", i);
      end
      // reset in mid-run must clear every field again
      @(posedge SYS_CLK_I);
      RSTN_I <= 1'b0;
      repeat (2) @(posedge SYS_CLK_I);
      RSTN_I <= 1'b1;
      #1;
      chk({24'h0, B_HALF_O}, 32'h02);
      for (int k = 0; k < 4; k++) begin
         rd(ofs[k], rdat);
         chk(rdat, 32'h0);
      end
      $display("test reset done");
      for (int k = 0; k < 4; k++) begin
         wr(ofs[k], 32'hffff_ffff);
         rd(ofs[k], rdat);
         chk(rdat, rmask[k]);
      end
      $display("test reserved bits done");
      wr(8'h10, 32'hffff_ffff);
      rd(8'h10, rdat);
      chk(rdat, 32'h0);
      rd(CTL_OFS, rdat);
      chk(rdat, 32'hf7f);
      @(posedge SYS_CLK_I);
      #1;
      chk(RDATA_O, 32'h0);
      $display("test unmapped done");
      // writes while the clock enable is low are lost
      @(posedge SYS_CLK_I);
      CE_I <= 1'b0;
      wr(CTL_OFS, 32'h0);
      @(posedge SYS_CLK_I);
      WR_I <= 1'b0;
      CE_I <= 1'b1;
      rd(CTL_OFS, rdat);
      chk(rdat, 32'hf7f);
      $display("test clock enable done");
      // 32-bit setup: second half follows the first mode register
      wr(CFG_OFS, 32'h0);
      wr(AMODE_OFS, 32'h7);
      wr(CTL_OFS, 32'hd);
      @(posedge SYS_CLK_I);
      WR_I <= 1'b0;
      #1;
      chk({24'h0, A_HALF_O}, 32'h9b);
      chk({24'h0, B_HALF_O}, 32'h1a);
      $display("test first half done");
      complete_run();
   end
endmodule : tb_tmc_regs
`default_nettype wire
